// ==== hw/rvp_pkg.sv ====
// Shared constants, modes, states and carrier types for the reset vector and priority block.
package rvp_pkg;

  // Register byte offsets on the Wishbone slave.
  localparam logic [7:0] RVP_OFS_CONFIG = 8'h00;
  localparam logic [7:0] RVP_OFS_PRIO = 8'h04;
  localparam logic [7:0] RVP_OFS_STATUS = 8'h08;

  // System configuration field positions.
  localparam int RVP_CFG_MAP_LSB = 4;
  localparam int RVP_CFG_RSV3 = 3;
  localparam int RVP_CFG_WDOG_DIS = 2;
  localparam int RVP_CFG_RSV1 = 1;
  localparam int RVP_CFG_EE_EN = 0;
  localparam logic [7:0] RVP_CFG_ERASED = 8'hFF;
  localparam logic [3:0] RVP_MAP_RESET = 4'hF;

  // Priority and miscellaneous register field positions and reset values.
  localparam int RVP_PRIO_BOOT = 7;
  localparam int RVP_PRIO_SPECIAL_MODE_BIT = 6;
  localparam int RVP_PRIO_MDA = 5;
  localparam int RVP_PRIO_IRV = 4;
  localparam logic [3:0] RVP_PSEL_RESET = 4'h5;

  // Reset vectors for normal and for special modes.
  localparam logic [15:0] RVP_VEC_POR_NORM = 16'hFFFE;
  localparam logic [15:0] RVP_VEC_CMF_NORM = 16'hFFFC;
  localparam logic [15:0] RVP_VEC_WDT_NORM = 16'hFFFA;
  localparam logic [15:0] RVP_VEC_POR_SPEC = 16'hBFFE;
  localparam logic [15:0] RVP_VEC_CMF_SPEC = 16'hBFFC;
  localparam logic [15:0] RVP_VEC_WDT_SPEC = 16'hBFFA;

  // Interrupt vectors; maskable vectors step down by two from the top one.
  localparam logic [15:0] RVP_VEC_NONMASKABLE_IRQ_PIN = 16'hFFF4;
  localparam logic [15:0] RVP_VEC_SWI = 16'hFFF6;
  localparam logic [15:0] RVP_VEC_ILLOP = 16'hFFF8;
  localparam logic [15:0] RVP_VEC_MASK_TOP = 16'hFFF2;
  localparam int RVP_NUM_MASKABLE = 15;
  localparam logic [4:0] RVP_SRC_NONMASKABLE_IRQ_PIN = 5'h10;
  localparam logic [4:0] RVP_SRC_ILLOP = 5'h11;
  localparam logic [4:0] RVP_SRC_SWI = 5'h12;
  localparam logic [4:0] RVP_SRC_NONE = 5'h1F;

  // Vector fetch length after reset release.
  localparam logic [1:0] RVP_FETCH_CYCLES = 2'h3;

  // Operating mode, encoded as the two mode pins {b, a}.
  typedef enum logic [1:0] {
    RVP_MODE_BOOT = 2'b00,
    RVP_MODE_TEST = 2'b01,
    RVP_MODE_SINGLE = 2'b10,
    RVP_MODE_EXP = 2'b11
  } rvp_mode_type;

  // Reset cause; a lower code wins.
  typedef enum logic [1:0] {
    RVP_CAUSE_POR = 2'b00,
    RVP_CAUSE_CMF = 2'b01,
    RVP_CAUSE_WDT = 2'b10
  } rvp_cause_type;

  // Sequencer states of the CPU start-up.
  typedef enum logic [1:0] {
    RVP_ST_RESET = 2'b00,
    RVP_ST_FETCH = 2'b01,
    RVP_ST_RUN = 2'b10
  } rvp_state_type;

  // Start-up state forced onto the CPU and the peripherals.
  typedef struct packed {
    logic ccr_x_mask;
    logic ccr_i_mask;
    logic ccr_stop_dis;
    logic [7:0] ram_reg_position;
    logic ports_expansion_bus;
    logic ports_hiz_input;
    logic [15:0] timer_count;
    logic [1:0] timer_prescale;
    logic [15:0] out_compare;
    logic [7:0] compare1_pin_mask;
    logic [7:0] compare_pin_action;
    logic [7:0] capture_edges;
    logic [8:0] timer_flags;
    logic [8:0] timer_enables;
    logic capture4_compare5_select;
    logic [1:0] compare5_output_action;
    logic periodic_irq_flag;
    logic periodic_irq_enable;
    logic [1:0] periodic_rate;
    logic pulse_accum_enable;
    logic spi_enable;
    logic [1:0] watchdog_rate;
    logic [3:0] sci_irq_enables;
    logic sci_tx_enable;
    logic sci_rx_enable;
    logic sci_nine_bit;
    logic sci_send_break;
    logic sci_wakeup;
    logic tx_data_empty;
    logic tx_complete;
    logic [6:0] sci_rx_status;
    logic adc_power_up;
    logic adc_conv_complete;
    logic eeprom_program;
    logic irq_edge_mode;
    logic stop_exit_delay;
    logic clock_monitor_on;
    logic clock_monitor_force;
  } rvp_init_type;

  localparam rvp_init_type RVP_INIT_BASE = '{
    ccr_x_mask: 1'b1, ccr_i_mask: 1'b1, ccr_stop_dis: 1'b1, ram_reg_position: 8'h01,
    ports_expansion_bus: 1'b0, ports_hiz_input: 1'b1, timer_count: 16'h0000,
    timer_prescale: 2'h0, out_compare: 16'hFFFF, compare1_pin_mask: 8'h00,
    compare_pin_action: 8'h00, capture_edges: 8'h00, timer_flags: 9'h000,
    timer_enables: 9'h000, capture4_compare5_select: 1'b0, compare5_output_action: 2'h0,
    periodic_irq_flag: 1'b0, periodic_irq_enable: 1'b0, periodic_rate: 2'h0,
    pulse_accum_enable: 1'b0, spi_enable: 1'b0, watchdog_rate: 2'h0,
    sci_irq_enables: 4'h0, sci_tx_enable: 1'b0, sci_rx_enable: 1'b0, sci_nine_bit: 1'b0,
    sci_send_break: 1'b0, sci_wakeup: 1'b0, tx_data_empty: 1'b1, tx_complete: 1'b1,
    sci_rx_status: 7'h00, adc_power_up: 1'b0, adc_conv_complete: 1'b0,
    eeprom_program: 1'b0, irq_edge_mode: 1'b0, stop_exit_delay: 1'b1,
    clock_monitor_on: 1'b0, clock_monitor_force: 1'b0
  };

endpackage

// ==== hw/rvp_reset_priority.sv ====
// Reset vector selection, reset start-up state, configuration and interrupt priority logic.
//
// The Wishbone register port and the register addresses were left to the implementer.
`timescale 1ns/1ps

module rvp_reset_priority (
  input wire logic clk_i, // 10 MHz bus clock.
  input wire logic rst_i, // System reset, synchronous, active high.
  input wire logic por_req_i, // Power-on or pin reset cause, held with reset.
  input wire logic clock_fail_req_i, // Clock monitor failure cause.
  input wire logic wdog_timeout_req_i, // Watchdog time-out cause.
  input wire logic mode_pin_a_i, // Mode pin A, asynchronous.
  input wire logic mode_pin_b_i, // Mode pin B, asynchronous.
  input wire logic reset_disable_test_bit_i, // Reset-disable bit of the test control register.
  input wire logic cpu_i_mask_i, // Maskable interrupt mask from the CPU.
  input wire logic cpu_x_mask_i, // Nonmaskable pin mask from the CPU.
  input wire logic [14:0] maskable_req_i, // Maskable flags in priority order.
  input wire logic [14:0] local_enable_i, // Local enables of the maskable flags.
  input wire logic nonmaskable_irq_pin_n_i, // Nonmaskable interrupt pin, active low.
  input wire logic illegal_op_req_i, // Illegal opcode trap request.
  input wire logic software_trap_req_i, // Software trap request.
  input wire logic wb_cyc_i, // Wishbone cycle.
  input wire logic wb_stb_i, // Wishbone strobe.
  input wire logic wb_we_i, // Wishbone write enable.
  input wire logic [7:0] wb_adr_i, // Wishbone byte address.
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
  input wire logic [31:0] wb_dat_i, // Wishbone write data.
  output logic [31:0] wb_dat_o, // Wishbone read data.
  output logic wb_ack_o, // Wishbone acknowledge.
  output rvp_pkg::rvp_init_type init_state_o, // Start-up state for CPU and peripherals.
  output logic periph_reset_o, // Peripherals load the start-up state while high.
  output logic watchdog_active_o, // Watchdog may force a reset.
  output logic vector_fetch_o, // CPU fetches the reset vector.
  output logic [15:0] reset_vector_o, // Address of the reset vector.
  output logic cpu_run_o, // CPU executes instructions.
  output logic irq_pending_o, // A request won in the previous cycle; registered.
  output logic [4:0] irq_source_o, // Winning source code.
  output logic [15:0] irq_vector_o, // Vector of the winning source.
  output logic [3:0] eeprom_map_select_o, // Eeprom placement.
  output logic eeprom_enable_o, // Eeprom enabled.
  output logic boot_rom_read_o, // Boot rom visible.
  output logic special_mode_bit_o, // Special mode active.
  output logic mode_select_a_o, // Expanded bus selected.
  output logic read_visibility_o // Internal reads shown on the bus.
);

  // Mode and interrupt pins cross into the clock domain through two flip-flops.
  logic [2:0] pin_meta_reg;
  logic [2:0] pin_sync_reg;

  always_ff @(posedge clk_i)
  begin
    pin_meta_reg <= {nonmaskable_irq_pin_n_i, mode_pin_b_i, mode_pin_a_i};
    pin_sync_reg <= pin_meta_reg;
  end

  // Mode seen on the pins now; the last reset cycle freezes it.
  rvp_pkg::rvp_mode_type pin_mode;
  logic pin_special;
  logic pin_keep_map;
  assign pin_mode = rvp_pkg::rvp_mode_type'(pin_sync_reg[1:0]);
  assign pin_special = pin_mode == rvp_pkg::RVP_MODE_BOOT || pin_mode == rvp_pkg::RVP_MODE_TEST;
  assign pin_keep_map = pin_mode == rvp_pkg::RVP_MODE_EXP || pin_mode == rvp_pkg::RVP_MODE_TEST;

  // State registers.
  rvp_pkg::rvp_mode_type mode_reg;
  rvp_pkg::rvp_cause_type cause_reg;
  rvp_pkg::rvp_state_type state_reg;
  logic rst_d_reg;
  logic [1:0] fetch_cnt_reg;
  logic [7:0] cfg_reg;
  logic [7:0] prio_reg;
  logic irv_written_reg;
  logic cfg_valid_reg;
  logic [15:0] reset_vector_reg;
  rvp_pkg::rvp_init_type init_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic irq_pending_reg;
  logic [4:0] irq_source_reg;
  logic [15:0] irq_vector_reg;

  // Cause of the reset now arriving; a lower code outranks a higher one.
  logic cause_any;
  rvp_pkg::rvp_cause_type cause_in;
  logic [7:0] cfg_hold_reg;
  assign cause_any = por_req_i || clock_fail_req_i || wdog_timeout_req_i;
  assign cause_in = por_req_i ? rvp_pkg::RVP_CAUSE_POR :
    clock_fail_req_i ? rvp_pkg::RVP_CAUSE_CMF : rvp_pkg::RVP_CAUSE_WDT;

  // Cause tracking; a bare reset is a pin reset, and the first cycle saves the configuration.
  always_ff @(posedge clk_i)
  begin
    rst_d_reg <= rst_i;
    if (rst_i && rst_d_reg)
    begin
      cause_reg <= (cause_any && (cause_in < cause_reg)) ? cause_in : cause_reg;
    end
    else if (rst_i)
    begin
      cause_reg <= cause_any ? cause_in : rvp_pkg::RVP_CAUSE_POR;
      cfg_hold_reg <= cfg_reg;
    end
  end

  // Reset vector by cause, page BF instead of page FF in special modes.
  logic [15:0] vec_norm;
  logic [15:0] vec_spec;
  assign vec_norm = (cause_reg == rvp_pkg::RVP_CAUSE_POR) ? rvp_pkg::RVP_VEC_POR_NORM :
    (cause_reg == rvp_pkg::RVP_CAUSE_CMF) ? rvp_pkg::RVP_VEC_CMF_NORM :
    rvp_pkg::RVP_VEC_WDT_NORM;
  assign vec_spec = (cause_reg == rvp_pkg::RVP_CAUSE_POR) ? rvp_pkg::RVP_VEC_POR_SPEC :
    (cause_reg == rvp_pkg::RVP_CAUSE_CMF) ? rvp_pkg::RVP_VEC_CMF_SPEC :
    rvp_pkg::RVP_VEC_WDT_SPEC;

  // Configuration value loaded on reset; retained fields survive a warm reset.
  logic [7:0] cfg_base;
  logic [7:0] cfg_rst_val;
  // Later reset cycles start from the saved copy, so stale pins early in reset cannot clobber it.
  assign cfg_base = cfg_valid_reg ? (rst_d_reg ? cfg_hold_reg : cfg_reg) : rvp_pkg::RVP_CFG_ERASED;
  always_comb
  begin
    cfg_rst_val = cfg_base;
    if (!pin_keep_map)
    begin
      cfg_rst_val[7:4] = rvp_pkg::RVP_MAP_RESET;
      cfg_rst_val[rvp_pkg::RVP_CFG_EE_EN] = 1'b1;
    end
    if (pin_mode == rvp_pkg::RVP_MODE_TEST)
    begin
      cfg_rst_val[rvp_pkg::RVP_CFG_EE_EN] = 1'b0;
    end
    cfg_rst_val[rvp_pkg::RVP_CFG_RSV3] = 1'b1;
    cfg_rst_val[rvp_pkg::RVP_CFG_RSV1] = 1'b1;
  end

  // Priority register value loaded on reset; mode bits taken from the pins at release, the select field fixed at RVP_PSEL_RESET.
  logic [7:0] prio_rst_val;
  assign prio_rst_val = {
    pin_mode == rvp_pkg::RVP_MODE_BOOT,
    pin_special,
    pin_sync_reg[0],
    pin_sync_reg[0], // Read visibility follows the expanded bus at reset.
    rvp_pkg::RVP_PSEL_RESET
  };

  // Start-up state; only port ownership depends on the mode.
  rvp_pkg::rvp_init_type init_val;
  always_comb
  begin
    init_val = rvp_pkg::RVP_INIT_BASE;
    init_val.ports_expansion_bus = pin_sync_reg[0];
    init_val.ports_hiz_input = !pin_sync_reg[0];
    init_val.watchdog_rate = rvp_pkg::RVP_INIT_BASE.watchdog_rate;
    init_val.tx_data_empty = rvp_pkg::RVP_INIT_BASE.tx_data_empty;
    init_val.adc_power_up = rvp_pkg::RVP_INIT_BASE.adc_power_up;
  end

  // Wishbone decode.
  logic wb_req;
  logic wb_wr;
  logic hit_cfg;
  logic hit_prio;
  logic hit_stat;
  logic special_now;
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];
  assign hit_cfg = (wb_adr_i[7:2] == rvp_pkg::RVP_OFS_CONFIG[7:2]);
  assign hit_prio = (wb_adr_i[7:2] == rvp_pkg::RVP_OFS_PRIO[7:2]);
  assign hit_stat = (wb_adr_i[7:2] == rvp_pkg::RVP_OFS_STATUS[7:2]);
  assign special_now = prio_reg[rvp_pkg::RVP_PRIO_SPECIAL_MODE_BIT];

  // Write merge for the configuration register; the two unused bits stay one.
  logic [7:0] cfg_wr_val;
  assign cfg_wr_val = {wb_dat_i[7:4], 1'b1, wb_dat_i[2], 1'b1, wb_dat_i[0]};

  // Write merge for the priority register, field by field.
  logic [7:0] prio_wr_val;
  logic psel_open;
  logic irv_open;
  assign psel_open = cpu_i_mask_i;
  assign irv_open = special_now || !irv_written_reg;
  assign prio_wr_val = {
    special_now ? wb_dat_i[7] : prio_reg[7],
    special_now ? (prio_reg[6] && wb_dat_i[6]) : prio_reg[6],
    special_now ? wb_dat_i[5] : prio_reg[5],
    irv_open ? wb_dat_i[4] : prio_reg[4],
    psel_open ? wb_dat_i[3:0] : prio_reg[3:0]
  };

  // Configuration and priority registers.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_reg <= pin_mode;
      cfg_reg <= cfg_rst_val;
      cfg_valid_reg <= 1'b1;
      prio_reg <= prio_rst_val;
      irv_written_reg <= 1'b0;
      init_reg <= init_val;
    end
    else
    begin
      if (wb_wr && hit_cfg)
      begin
        cfg_reg <= cfg_wr_val;
      end
      if (wb_wr && hit_prio)
      begin
        prio_reg <= prio_wr_val;
        irv_written_reg <= 1'b1;
      end
    end
  end

  // Start-up sequencer: hold in reset, fetch the vector, then run.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= rvp_pkg::RVP_ST_RESET;
      fetch_cnt_reg <= 2'h0;
    end
    else
    begin
      case (state_reg)
        rvp_pkg::RVP_ST_RESET:
        begin
          state_reg <= rvp_pkg::RVP_ST_FETCH;
          fetch_cnt_reg <= 2'h1;
        end
        rvp_pkg::RVP_ST_FETCH:
        begin
          if (fetch_cnt_reg == rvp_pkg::RVP_FETCH_CYCLES)
          begin
            state_reg <= rvp_pkg::RVP_ST_RUN;
          end
          else
          begin
            fetch_cnt_reg <= fetch_cnt_reg + 2'h1;
          end
        end
        rvp_pkg::RVP_ST_RUN:
        begin
          state_reg <= rvp_pkg::RVP_ST_RUN;
        end
        default:
        begin
          state_reg <= rvp_pkg::RVP_ST_RESET;
        end
      endcase
    end
  end

  // The vector is registered when the sequencer leaves reset, so it is stable while fetched.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      reset_vector_reg <= rvp_pkg::RVP_VEC_POR_NORM;
    end
    else if (state_reg == rvp_pkg::RVP_ST_RESET)
    begin
      reset_vector_reg <= (mode_reg == rvp_pkg::RVP_MODE_BOOT ||
        mode_reg == rvp_pkg::RVP_MODE_TEST) ? vec_spec : vec_norm;
    end
  end

  // Maskable requests after global and local masking.
  logic [14:0] mask_live;
  logic [3:0] psel;
  logic [3:0] promo_idx;
  assign mask_live = maskable_req_i & local_enable_i & {15{!cpu_i_mask_i}};
  assign psel = prio_reg[3:0];

  // Map the priority select code onto the fixed order; the reserved code means IRQ.
  always_comb
  begin
    case (psel)
      4'h0: promo_idx = 4'd10;
      4'h1: promo_idx = 4'd11;
      4'h2: promo_idx = 4'd12;
      4'h3: promo_idx = 4'd13;
      4'h4: promo_idx = 4'd14;
      4'h5: promo_idx = 4'd0;
      4'h6: promo_idx = 4'd0;
      4'h7: promo_idx = 4'd1;
      default: promo_idx = psel - 4'd6;
    endcase
  end

  // Fixed order winner: the lowest index set; a loop walks downward so index 0 wins.
  logic [3:0] fixed_idx;
  logic fixed_any;
  always_comb
  begin
    fixed_idx = 4'd0;
    fixed_any = 1'b0;
    for (int i = rvp_pkg::RVP_NUM_MASKABLE - 1; i >= 0; i--)
    begin
      if (mask_live[i])
      begin
        fixed_idx = 4'(i);
        fixed_any = 1'b1;
      end
    end
  end

  // Winner across all sources; vectors never move with promotion.
  logic nonmaskable_irq_pin_live;
  logic [3:0] win_idx;
  logic [4:0] win_src;
  logic [15:0] win_vec;
  logic win_any;
  assign nonmaskable_irq_pin_live = !pin_sync_reg[2] && !cpu_x_mask_i;
  assign win_idx = mask_live[promo_idx] ? promo_idx : fixed_idx;
  assign win_any = nonmaskable_irq_pin_live || illegal_op_req_i || software_trap_req_i || fixed_any;
  assign win_src = nonmaskable_irq_pin_live ? rvp_pkg::RVP_SRC_NONMASKABLE_IRQ_PIN :
    illegal_op_req_i ? rvp_pkg::RVP_SRC_ILLOP :
    software_trap_req_i ? rvp_pkg::RVP_SRC_SWI :
    fixed_any ? {1'b0, win_idx} : rvp_pkg::RVP_SRC_NONE;
  assign win_vec = nonmaskable_irq_pin_live ? rvp_pkg::RVP_VEC_NONMASKABLE_IRQ_PIN :
    illegal_op_req_i ? rvp_pkg::RVP_VEC_ILLOP :
    software_trap_req_i ? rvp_pkg::RVP_VEC_SWI :
    fixed_any ? (rvp_pkg::RVP_VEC_MASK_TOP - {11'h000, win_idx, 1'b0}) : 16'h0000;

  // Winner registered every cycle; the CPU samples it at its instruction boundary.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_pending_reg <= 1'b0;
      irq_source_reg <= rvp_pkg::RVP_SRC_NONE;
      irq_vector_reg <= 16'h0000;
    end
    else
    begin
      irq_pending_reg <= win_any;
      irq_source_reg <= win_src;
      irq_vector_reg <= win_vec;
    end
  end

  // Read mux; unmapped addresses read zero.
  logic [31:0] rd_mux;
  logic [31:0] stat_word;
  assign stat_word = {22'h00_0000, watchdog_active_o, state_reg, cause_reg, mode_reg, 3'h0};
  assign rd_mux = hit_cfg ? {24'h00_0000, cfg_reg} :
    hit_prio ? {24'h00_0000, prio_reg} :
    hit_stat ? stat_word : 32'h0000_0000;

  // Single-wait acknowledge; ack drops the cycle after it is given.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      ack_reg <= wb_req;
      rdata_reg <= wb_req ? rd_mux : rdata_reg;
    end
  end

  // Watchdog activity: normal modes follow the disable bit, special modes the test bit.
  logic wdog_normal;
  assign wdog_normal = !cfg_reg[rvp_pkg::RVP_CFG_WDOG_DIS];
  assign watchdog_active_o = (mode_reg == rvp_pkg::RVP_MODE_BOOT ||
    mode_reg == rvp_pkg::RVP_MODE_TEST) ? !reset_disable_test_bit_i : wdog_normal;

  // Output drive.
  assign wb_dat_o = rdata_reg;
  assign wb_ack_o = ack_reg;
  assign init_state_o = init_reg;
  assign periph_reset_o = rst_d_reg;
  assign vector_fetch_o = (state_reg == rvp_pkg::RVP_ST_FETCH);
  assign reset_vector_o = reset_vector_reg;
  assign cpu_run_o = (state_reg == rvp_pkg::RVP_ST_RUN);
  assign irq_pending_o = irq_pending_reg;
  assign irq_source_o = irq_source_reg;
  assign irq_vector_o = irq_vector_reg;
  assign eeprom_map_select_o = cfg_reg[7:rvp_pkg::RVP_CFG_MAP_LSB];
  assign eeprom_enable_o = cfg_reg[rvp_pkg::RVP_CFG_EE_EN];
  assign boot_rom_read_o = prio_reg[rvp_pkg::RVP_PRIO_BOOT];
  assign special_mode_bit_o = prio_reg[rvp_pkg::RVP_PRIO_SPECIAL_MODE_BIT];
  assign mode_select_a_o = prio_reg[rvp_pkg::RVP_PRIO_MDA];
  assign read_visibility_o = prio_reg[rvp_pkg::RVP_PRIO_IRV];

endmodule

// ==== test/rvp_cpu_model.sv ====
// Behavioural CPU core owning the condition-code interrupt masks.
`timescale 1ns/1ps
module rvp_cpu_model (
  input wire logic clk_i, // Clock.
  input wire logic cpu_run_i, // Execution allowed.
  input wire logic unmask_i, // Software clears the masks.
  output logic i_mask_o, // Maskable mask.
  output logic x_mask_o // Nonmaskable pin mask.
);
  // Masks stay set from reset until software running clears them.
  always_ff @(posedge clk_i)
  begin
    i_mask_o <= !(cpu_run_i && unmask_i);
    x_mask_o <= !(cpu_run_i && unmask_i);
  end
endmodule

// ==== test/rvp_reset_priority_properties.sv ====
// Port-level properties of the reset vector and priority block.
`timescale 1ns/1ps
module rvp_reset_priority_properties (
  input wire logic clk_i, // Clock.
  input wire logic rst_i, // Reset.
  input wire logic periph_reset_o, // Start-up load.
  input wire rvp_pkg::rvp_init_type init_state_o, // Start-up state.
  input wire logic vector_fetch_o, // Fetch.
  input wire logic cpu_run_o, // Run.
  input wire logic [15:0] reset_vector_o, // Reset vector.
  input wire logic special_mode_bit_o, // Special mode.
  input wire logic illegal_op_req_i, // Illegal trap.
  input wire logic software_trap_req_i, // Software trap.
  input wire logic cpu_i_mask_i, // I mask.
  input wire logic cpu_x_mask_i, // X mask.
  input wire logic irq_pending_o, // Pending.
  input wire logic [4:0] irq_source_o, // Winner.
  input wire logic [15:0] irq_vector_o // Winner vector.
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // The start-up image is checked in the cycle after release, when it was last loaded.
  AST_INIT_CPU: assert property (periph_reset_o |-> init_state_o.ccr_x_mask &&
    init_state_o.ccr_i_mask && init_state_o.ccr_stop_dis && init_state_o.ram_reg_position == 8'h01)
    else $error("cpu start-up state wrong");
  AST_INIT_PERIPH: assert property (periph_reset_o |->
    init_state_o.timer_count == 16'h0000 && init_state_o.out_compare == 16'hFFFF &&
    init_state_o.tx_data_empty && !init_state_o.sci_nine_bit)
    else $error("peripheral start-up state wrong");
  AST_INIT_SYS: assert property (periph_reset_o |->
    init_state_o.stop_exit_delay && !init_state_o.clock_monitor_on &&
    !init_state_o.clock_monitor_force && !init_state_o.eeprom_program)
    else $error("system start-up state wrong");
  // Vector fetch lasts three cycles and hands over to execution.
  AST_FETCH3: assert property ($rose(vector_fetch_o) |->
    vector_fetch_o[*3] ##1 (!vector_fetch_o && cpu_run_o))
    else $error("fetch length wrong");
  AST_VEC: assert property (vector_fetch_o |->
    reset_vector_o[15:8] == (special_mode_bit_o ? 8'hBF : 8'hFF))
    else $error("reset vector page wrong");
  // Resolution is registered, so the winner shows one cycle after its cause.
  AST_ILLOP: assert property (illegal_op_req_i |=>
    irq_pending_o && irq_source_o inside {5'h10, 5'h11})
    else $error("illegal trap lost");
  AST_MASKHIDE: assert property (cpu_i_mask_i && cpu_x_mask_i && !illegal_op_req_i &&
    !software_trap_req_i |=> !irq_pending_o) else $error("masked request won");
  AST_MASKVEC: assert property (irq_pending_o && irq_source_o < 5'h0F |->
    irq_vector_o == 16'hFFF2 - {10'h000, irq_source_o, 1'b0}) else $error("maskable vector wrong");
  // Main scenarios.
  cover property ($rose(cpu_run_o));
  cover property (irq_pending_o && irq_source_o < 5'h0F);
  cover property (irq_pending_o && irq_source_o == 5'h12);
  cover property (irq_pending_o && irq_source_o == 5'h10);
endmodule
bind rvp_reset_priority rvp_reset_priority_properties u_props (.clk_i, .rst_i, .periph_reset_o,
  .init_state_o, .vector_fetch_o, .cpu_run_o, .reset_vector_o, .special_mode_bit_o,
  .illegal_op_req_i, .software_trap_req_i, .cpu_i_mask_i, .cpu_x_mask_i, .irq_pending_o,
  .irq_source_o, .irq_vector_o);

// ==== test/rvp_reset_priority_tb_top.sv ====
// Self-checking bench of the reset vector and priority block.
`timescale 1ns/1ps
module rvp_reset_priority_tb_top;
  logic clk_i = 0, rst_i = 1, por_req_i = 0, clock_fail_req_i = 0, wdog_timeout_req_i = 0;
  logic mode_pin_a_i = 0, mode_pin_b_i = 1, reset_disable_test_bit_i = 0, unmask = 0;
  logic illegal_op_req_i = 0, software_trap_req_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic nonmaskable_irq_pin_n_i = 1;
  logic [14:0] maskable_req_i = 0, local_enable_i = 0;
  logic [7:0] wb_adr_i = 0, cfg = 8'hFF, e;
  logic [31:0] wb_dat_i = 0, wb_dat_o, q, d;
  logic cpu_i_mask_i, cpu_x_mask_i, wb_ack_o, watchdog_active_o, cpu_run_o, irq_pending_o;
  logic eeprom_enable_o, boot_rom_read_o, special_mode_bit_o, mode_select_a_o, read_visibility_o;
  logic [15:0] reset_vector_o, irq_vector_o;
  logic [4:0] irq_source_o, w;
  logic [3:0] eeprom_map_select_o, p;
  logic [1:0] m;
  int fail_count = 0, checks_done = 0;
  rvp_reset_priority dut (.clk_i, .rst_i, .por_req_i, .clock_fail_req_i, .wdog_timeout_req_i,
    .mode_pin_a_i, .mode_pin_b_i, .reset_disable_test_bit_i, .cpu_i_mask_i, .cpu_x_mask_i,
    .maskable_req_i, .local_enable_i, .nonmaskable_irq_pin_n_i, .illegal_op_req_i,
    .software_trap_req_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'h1),
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .init_state_o(), .periph_reset_o(), .watchdog_active_o,
    .vector_fetch_o(), .reset_vector_o, .cpu_run_o, .irq_pending_o, .irq_source_o,
    .irq_vector_o, .eeprom_map_select_o, .eeprom_enable_o, .boot_rom_read_o,
    .special_mode_bit_o, .mode_select_a_o, .read_visibility_o);
  rvp_cpu_model cpu (.clk_i, .cpu_run_i(cpu_run_o), .unmask_i(unmask), .i_mask_o(cpu_i_mask_i),
    .x_mask_o(cpu_x_mask_i));
  always #50 clk_i = ~clk_i;
  // Classic single cycle; the request holds until ack is sampled at an edge.
  task wb(input logic wr, input logic [7:0] a, input logic [31:0] dw, output logic [31:0] r);
    int n;
    begin
      wb_cyc_i <= 1;
      wb_stb_i <= 1;
      wb_we_i <= wr;
      wb_adr_i <= a;
      wb_dat_i <= dw;
      n = 0;
      do
      begin
        @(posedge clk_i);
        n++;
      end
      while (wb_ack_o !== 1'b1 && n < 50);
      if (wb_ack_o !== 1'b1)
      begin
        fail_count++;
        $display("ERROR %0t bus acknowledge missing", $time);
      end
      r = wb_dat_o;
      wb_cyc_i <= 0;
      wb_stb_i <= 0;
      @(posedge clk_i);
    end
  endtask
  task chk(input logic [31:0] g, input logic [31:0] x);
    begin
      checks_done++;
      if (g !== x)
      begin
        fail_count++;
        $display("ERROR %0t got %h want %h", $time, g, x);
      end
    end
  endtask
  // All causes at and below the chosen one are raised together, so the highest must win.
  task rst_dut(input logic [1:0] md, input int c);
    begin
      rst_i <= 1;
      {mode_pin_b_i, mode_pin_a_i} <= md;
      {wdog_timeout_req_i, clock_fail_req_i, por_req_i} <= 3'b111 << c;
      repeat (4) @(posedge clk_i);
      rst_i <= 0;
      {wdog_timeout_req_i, clock_fail_req_i, por_req_i} <= 3'h0;
      repeat (5) @(posedge clk_i);
    end
  endtask
  // Promoted source first, then the fixed order from bit 0 upwards.
  function logic [4:0] win(input logic [14:0] r, input logic [3:0] s);
    int t;
    begin
      t = s < 5 ? 10 + s : s < 7 ? 0 : s - 6;
      win = 5'h1F;
      for (int k = 14; k >= 0; k--)
        if (r[k]) win = 5'(k);
      if (r[t]) win = 5'(t);
    end
  endfunction
  task stop_test;
    begin
      $display("checks %0d errors %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial
  begin
    #3_000_000;
    fail_count++;
    $display("ERROR %0t test timeout", $time);
    stop_test;
  end
  // Every mode meets every reset cause once over the twelve passes.
  initial
  begin
    void'($urandom(72));
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    repeat (5) @(posedge clk_i);
    wb(0, 8'h0C, 0, q);
    chk(q, 0);
    for (int i = 0; i < 12; i++)
    begin
      m = 2'(i);
      d = $urandom;
      wb(1, 8'h00, d, q);
      wb(0, 8'h00, 0, q);
      cfg = d[7:0] | 8'h0A;
      chk(q, cfg);
      reset_disable_test_bit_i <= d[8];
      rst_dut(m, i % 3);
      if (!m[0]) cfg = cfg | 8'hF1;
      if (m == 2'b01) cfg[0] = 0;
      e = {m == 0, m < 2, m[0], m[0], 4'h5};
      wb(0, 8'h00, 0, q);
      chk(q, cfg);
      chk({eeprom_map_select_o, eeprom_enable_o}, {cfg[7:4], cfg[0]});
      chk(reset_vector_o, (m < 2 ? 16'hBFFE : 16'hFFFE) - 2 * (i % 3));
      chk(watchdog_active_o, m < 2 ? !d[8] : !cfg[2]);
      chk({boot_rom_read_o, special_mode_bit_o, mode_select_a_o, read_visibility_o}, e[7:4]);
      wb(0, 8'h04, 0, q);
      chk(q, e);
      p = 4'($urandom);
      wb(1, 8'h04, {e[7:4], p}, q);
      unmask <= 1;
      repeat (2) @(posedge clk_i);
      wb(1, 8'h04, {e[7:4], ~p}, q);
      wb(0, 8'h04, 0, q);
      chk(q, {e[7:4], p});
      maskable_req_i <= 15'($urandom);
      local_enable_i <= i[0] ? 15'h7FFF : 15'($urandom);
      repeat (3) @(posedge clk_i);
      w = win(maskable_req_i & local_enable_i, p);
      chk(irq_source_o, w);
      if (!w[4]) chk(irq_vector_o, 16'hFFF2 - 2 * w);
      illegal_op_req_i <= i[0];
      software_trap_req_i <= 1;
      nonmaskable_irq_pin_n_i <= !i[1];
      repeat (4) @(posedge clk_i);
      chk(irq_source_o, i[1] ? 5'h10 : i[0] ? 5'h11 : 5'h12);
      illegal_op_req_i <= 0;
      software_trap_req_i <= 0;
      nonmaskable_irq_pin_n_i <= 1;
      unmask <= 0;
      repeat (3) @(posedge clk_i);
      chk(irq_pending_o, 0);
    end
    stop_test;
  end
endmodule
